// *** hw/bpmsi_regs.vh ***
// Purpose: Offsets, field positions, reset values for the power management
//          and slot identification register bank.
// Assumes: 32-bit Wishbone, byte addresses equal configuration offsets.
// Notes:   Definitions only.
`ifndef BPMSI_REGS_VH
`define BPMSI_REGS_VH

`define BPMSI_OFF_PMCS      8'h94
`define BPMSI_OFF_RSVD0     8'h98
`define BPMSI_OFF_RSVD1     8'h9C
`define BPMSI_OFF_SLOT      8'hA0
`define BPMSI_OFF_IRQ_STAT  8'hC0
`define BPMSI_OFF_IRQ_MASK  8'hC4
`define BPMSI_OFF_SLOT_EN   8'hC8

`define BPMSI_PS_D0         2'h0
`define BPMSI_PS_D3         2'h3
`define BPMSI_BIT_PME_EN    8
`define BPMSI_BIT_PME_STAT  15
`define BPMSI_SLOT_CAP_ID   8'h04
`define BPMSI_SLOT_NEXT     8'hB0

`define BPMSI_IRQ_PME       0
`define BPMSI_IRQ_DRESET    1
`define BPMSI_IRQ_W         2

`endif

// *** hw/bpmsi_top.v ***
// Purpose: Power management control/status, bridge support extension and
//          slot identification registers reached over classic Wishbone.
// Assumes: Single 125 MHz clock, synchronous active-high reset.
// Notes:   Single-cycle ack, one cycle after the request is seen.
//
// Summary of operation
// - Two-bit power state at 1:0, resets D0
// - Writes of codes 01 or 10 are discarded
// - D3 to D0 write pulses internal device reset
// - Bit 8 enables power event output, cleared by reset
// - Bit 15 event status, write one clears
// - Data select, scale, data byte read zero
// - Bit 22 reads zero
// - Bit 23 reads zero
// - Slot slot_cap_identifier 04h, enabled by EEPROM
// - Slot capability next pointer reads B0h
// - Slot number, first flag, chassis writable
// - Offsets 98h to 9Ch read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
`include "bpmsi_regs.vh"

module bpmsi_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        pme_event_i,
  input  wire        eeprom_slot_en_i,
  input  wire        eeprom_load_i,
  output reg         power_event_out_n,
  output reg         dev_reset_o,
  output reg         irq_o,
  output reg  [1:0]  power_state_o
);

  reg [1:0]             pstate_r;
  reg                   pme_en_r;
  reg                   pme_stat_r;
  reg [4:0]             slot_num_r;
  reg                   first_r;
  reg [7:0]             chassis_r;
  reg                   slot_en_r;
  reg [`BPMSI_IRQ_W-1:0] irq_stat_r;
  reg [`BPMSI_IRQ_W-1:0] irq_mask_r;
  reg [31:0]            rd_nxt;

  wire req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr    = req & wb_we_i;
  wire wr_pm = wr & (wb_adr_i == `BPMSI_OFF_PMCS);
  wire wr_sl = wr & (wb_adr_i == `BPMSI_OFF_SLOT);
  wire wr_is = wr & (wb_adr_i == `BPMSI_OFF_IRQ_STAT);
  wire wr_im = wr & (wb_adr_i == `BPMSI_OFF_IRQ_MASK);
  wire wr_se = wr & (wb_adr_i == `BPMSI_OFF_SLOT_EN);
  wire [1:0] ps_wr = wb_dat_i[1:0];
  // Only 00 and 11 are legal; the other codes leave the state alone
  wire ps_ok  = (ps_wr == `BPMSI_PS_D0) | (ps_wr == `BPMSI_PS_D3);
  wire ps_upd = wr_pm & wb_sel_i[0] & ps_ok;
  wire d3_to_d0 = ps_upd & (pstate_r == `BPMSI_PS_D3) & (ps_wr == `BPMSI_PS_D0);
  wire [`BPMSI_IRQ_W-1:0] irq_ev = {d3_to_d0, pme_event_i & ~pme_stat_r};

  // Read mux; unmapped and reserved words read zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (wb_adr_i)
      `BPMSI_OFF_PMCS: begin
        rd_nxt[1:0]                = pstate_r;
        rd_nxt[`BPMSI_BIT_PME_EN]  = pme_en_r;
        rd_nxt[`BPMSI_BIT_PME_STAT] = pme_stat_r;
        // Bits 7:2, 14:9, 31:16 stay zero
      end
      `BPMSI_OFF_RSVD0: rd_nxt = 32'h00000000;
      `BPMSI_OFF_RSVD1: rd_nxt = 32'h00000000;
      `BPMSI_OFF_SLOT: begin
        // Hidden capability reads zero until enabled by EEPROM load or a write to C8h
        if (slot_en_r) begin
          rd_nxt[7:0]   = `BPMSI_SLOT_CAP_ID;
          rd_nxt[15:8]  = `BPMSI_SLOT_NEXT;
          rd_nxt[20:16] = slot_num_r;
          rd_nxt[21]    = first_r;
          rd_nxt[31:24] = chassis_r;
        end
      end
      `BPMSI_OFF_IRQ_STAT: rd_nxt[`BPMSI_IRQ_W-1:0] = irq_stat_r;
      `BPMSI_OFF_IRQ_MASK: rd_nxt[`BPMSI_IRQ_W-1:0] = irq_mask_r;
      `BPMSI_OFF_SLOT_EN:  rd_nxt[0] = slot_en_r;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Bus answer: ack one cycle after the request, dropped the next cycle
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_nxt : 32'h00000000;
    end
  end

  // Power management word; byte enables gate each lane
  always @(posedge clk) begin
    if (rst) begin
      pstate_r    <= `BPMSI_PS_D0;
      pme_en_r    <= 1'b0;
      pme_stat_r  <= 1'b0;
      dev_reset_o <= 1'b0;
    end else begin
      if (ps_upd)
        pstate_r <= ps_wr;
      // Reset pulse only; the conventional-bus reset is not touched
      dev_reset_o <= d3_to_d0;
      if (wr_pm & wb_sel_i[1])
        pme_en_r <= wb_dat_i[`BPMSI_BIT_PME_EN];
      // Set wins over a same-cycle clear so no event is lost
      if (pme_event_i)
        pme_stat_r <= 1'b1;
      else if (wr_pm & wb_sel_i[1] & wb_dat_i[`BPMSI_BIT_PME_STAT])
        pme_stat_r <= 1'b0;
    end
  end

  // Slot identification storage and its enable
  always @(posedge clk) begin
    if (rst) begin
      slot_num_r <= 5'h00;
      first_r    <= 1'b0;
      chassis_r  <= 8'h00;
      slot_en_r  <= 1'b0;
    end else begin
      if (eeprom_load_i)
        slot_en_r <= eeprom_slot_en_i;
      else if (wr_se & wb_sel_i[0])
        slot_en_r <= wb_dat_i[0];
      if (wr_sl & slot_en_r & wb_sel_i[2]) begin
        slot_num_r <= wb_dat_i[20:16];
        first_r    <= wb_dat_i[21];
      end
      if (wr_sl & slot_en_r & wb_sel_i[3])
        chassis_r <= wb_dat_i[31:24];
    end
  end

  // Interrupt status, write-one-to-clear, set wins over clear
  always @(posedge clk) begin
    if (rst) begin
      irq_stat_r <= {`BPMSI_IRQ_W{1'b0}};
      irq_mask_r <= {`BPMSI_IRQ_W{1'b0}};
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= irq_ev |
        (irq_stat_r & ~((wr_is & wb_sel_i[0]) ? wb_dat_i[`BPMSI_IRQ_W-1:0]
                                               : {`BPMSI_IRQ_W{1'b0}}));
      if (wr_im & wb_sel_i[0])
        irq_mask_r <= wb_dat_i[`BPMSI_IRQ_W-1:0];
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Event pin low while status is set and enabled
  always @(posedge clk) begin
    if (rst) begin
      power_event_out_n <= 1'b1;
      power_state_o     <= `BPMSI_PS_D0;
    end else begin
      power_event_out_n <= ~(pme_en_r & pme_stat_r);
      power_state_o     <= pstate_r;
    end
  end

endmodule // bpmsi_top
`default_nettype wire

// *** verification/bpmsi_eeprom.sv ***
// Purpose: Boot loader model that offers the slot capability enable
// Assumes: Bench asks for a load; one clock
// Notes: Value is only valid in the load cycle
`timescale 1ns/100ps
`default_nettype none
module bpmsi_eeprom (
  input  wire logic clk,
  input  wire logic req,
  input  wire logic val,
  output var  logic load = 1'b0,
  output var  logic slot_en = 1'b0
);
  // Value toggles outside the load so a stale copy cannot pass
  always @(posedge clk) begin
    load <= req;
    slot_en <= req ? val : ~slot_en;
  end
endmodule // bpmsi_eeprom
`default_nettype wire

// *** verification/bpmsi_properties.sv ***
// Purpose: Port checker for the power and slot register bank
// Assumes: Request held through its ack cycle
// Notes: Read checks use the held address
`timescale 1ns/100ps
`default_nettype none
module bpmsi_chk (
  input wire logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic [1:0] power_state_o,
  input wire logic dev_reset_o, power_event_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_a = wb_ack_o && !wb_we_i;
  wire wr_t = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_follow: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ps_legal: assert property (power_state_o != 2'h1 && power_state_o != 2'h2)
    else $error("bad power state");
  a_ps_keep: assert property (wr_t && wb_adr_i == 8'h94 && (^wb_dat_i[1:0])
    |=> $stable(power_state_o) [*2]) else $error("state changed");
  a_dreset_d0: assert property (dev_reset_o |-> ##[0:2] power_state_o == 2'h0)
    else $error("reset not in D0");
  a_pm_zero: assert property (rd_a && wb_adr_i == 8'h94
    |-> (wb_dat_o & 32'hFFC0_7EFC) == 32'h0) else $error("power rsvd set");
  a_rsvd_zero: assert property (rd_a && wb_adr_i[7:3] == 5'h13 |-> wb_dat_o == 32'h0)
    else $error("reserved nonzero");
  a_slot_fix: assert property (rd_a && wb_adr_i == 8'hA0
    |-> wb_dat_o[15:0] inside {16'h0, 16'hB004} && wb_dat_o[23:22] == 2'h0)
    else $error("slot header bad");
  c_dreset: cover property (dev_reset_o);
  c_pme: cover property (!power_event_out_n);
  c_slot: cover property (rd_a && wb_adr_i == 8'hA0 && wb_dat_o[2]);
endmodule // bpmsi_chk
bind bpmsi_top bpmsi_chk bpmsi_chk_i (.*);
`default_nettype wire

// *** verification/tb_bpmsi_top.sv ***
// Purpose: Register test of the power and slot register bank
// Assumes: 125 MHz clock, classic Wishbone tasks
// Notes: Expected words built from the field layout
`timescale 1ns/100ps
`default_nettype none
module tb_bpmsi_top;
  logic clk = 0, rst = 1, cyc = 0, we = 0, pme = 0, req = 0, val = 0, seen = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] wd = 0, rdat;
  wire [31:0] dat_o;
  wire ack, load, slot_en, pme_n, drst, irq;
  wire [1:0] ps;
  int n_errors = 0, n_compared = 0, cyc_n = 0;
  // Two reserved words and one unmapped word, all read zero
  logic [7:0] adr_t [3] = '{8'h98, 8'h9C, 8'h50};
  bpmsi_top bpmsi_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pme_event_i(pme), .eeprom_slot_en_i(slot_en),
    .eeprom_load_i(load), .power_event_out_n(pme_n), .dev_reset_o(drst),
    .irq_o(irq), .power_state_o(ps));
  bpmsi_eeprom bpmsi_eeprom_i (.clk(clk), .req(req), .val(val), .load(load),
    .slot_en(slot_en));
  initial forever #4 clk = ~clk;
  // Hang guard; the run needs about a hundred cycles
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (drst) seen <= 1;
    if (cyc_n == 4000) begin
      n_errors++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data is taken at the ack edge, then one idle cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 0, 4'hF);
    chk(rdat, e);
  endtask
  task test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(8'h94, 0);
    rd(8'hA0, 0);
    // Slot writes while the capability is hidden must be dropped
    xfer(1, 8'hA0, 32'hFFFF_FFFF, 4'hF);
    xfer(1, 8'h94, 32'hFFFF_FFFF, 4'hF);
    rd(8'h94, 32'h103);
    chk(ps, 2'h3);
    for (int i = 1; i < 3; i++) begin
      xfer(1, 8'h94, 32'h100 | i, 4'hF);
      rd(8'h94, 32'h103);
    end
    pme <= 1;
    @(posedge clk);
    pme <= 0;
    rd(8'h94, 32'h8103);
    chk(pme_n, 0);
    xfer(1, 8'h94, 32'h103, 4'hF);
    rd(8'h94, 32'h8103);
    xfer(1, 8'h94, 32'h8103, 4'hF);
    rd(8'h94, 32'h103);
    chk(pme_n, 1);
    xfer(1, 8'h94, 0, 4'h2);
    rd(8'h94, 32'h3);
    xfer(1, 8'h94, 0, 4'hF);
    rd(8'h94, 0);
    chk(ps, 2'h0);
    chk(seen, 1);
    chk(drst, 0);
    chk(irq, 0);
    xfer(1, 8'hC4, 2, 4'hF);
    @(posedge clk);
    chk(irq, 1);
    xfer(1, 8'hC0, 3, 4'hF);
    @(posedge clk);
    chk(irq, 0);
    req <= 1;
    val <= 1;
    @(posedge clk);
    req <= 0;
    repeat (2) @(posedge clk);
    rd(8'hA0, 32'hB004);
    xfer(1, 8'hA0, 32'hFFFF_FFFF, 4'hF);
    rd(8'hA0, 32'hFF3F_B004);
    foreach (adr_t[k]) begin
      xfer(1, adr_t[k], 32'hFFFF_FFFF, 4'hF);
      rd(adr_t[k], 0);
    end
    test_done;
  end
endmodule // tb_bpmsi_top
`default_nettype wire
